// file: core/bdr_defs.svh
`ifndef BDR_DEFS_SVH
`define BDR_DEFS_SVH
// Notes on behaviour
// - Startup duty is (n+1) sixteenths of full drive; field resets to 0111.
// - Startup electrical rate is (n+1) times 2 Hz; field resets to 0011.
// - Speed loop integral gain is scaled by two to the power n minus 7.
// - Speed output pin carries electrical rate at 0, commutation rate at 1.
// - Maximum electrical rate is (2^(8+n) - 1) times 0.1 Hz; resets to 101.
// - Commutation is advanced by n steps of 1.875 electrical degrees.
// - Two-bit mode picks indirect duty, direct duty, current or speed loop.
// - Unmasked faults are always reported; motor stops on them only if halt bit set.
// - Serial duty is 7 plus 3n percent; zero selects measured input duty.
// - Automatic restart after sync loss is permitted only when bit is 1.
// - Braking while the drive input is inactive only when brake bit is 1.
// - Commutation steps 1 to 6 forward at 0, 6 down to 1 at 1.
// - Run 0 disables outputs and coasts; run 1 starts and runs; resets to 1.
// - Ten mask bits, one per fault detector; 1 disables it; reset 0.
// - Report word: bit 15 summary, 14 power-on, 13 serial error, faults below.

// Clock and rate constants.
`define BDR_CLK_HZ          10000000
`define BDR_START_STEP_HZ   2
`define BDR_MAX_STEP_DHZ    1
`define BDR_START_MOD       (`BDR_CLK_HZ / `BDR_START_STEP_HZ)
`define BDR_MAX_MOD         (`BDR_CLK_HZ * 10 / `BDR_MAX_STEP_DHZ)

// Register addresses.
`define BDR_ADDR_STARTUP    4'h0
`define BDR_ADDR_LIMITS     4'h1
`define BDR_ADDR_RUN        4'h2
`define BDR_ADDR_MASK       4'h3
`define BDR_ADDR_REPORT     4'h4
`define BDR_ADDR_IRQ_STAT   4'h5
`define BDR_ADDR_IRQ_EN     4'h6
`define BDR_ADDR_IRQ_CLR    4'h7

// Reset values and writable bits.
`define BDR_STARTUP_RST     16'h0773
`define BDR_LIMITS_RST      16'h0758
`define BDR_RUN_RST         16'h0009
`define BDR_CFG_BITS        16'h0fff
`define BDR_FAULT_BITS      16'h0ebf
`define BDR_REPORT_RST      16'hc000

// Field positions.
`define BDR_SS_LSB          0
`define BDR_SDUTY_LSB       4
`define BDR_SP_LSB          8
`define BDR_LEAD_LSB        0
`define BDR_MAXR_LSB        4
`define BDR_SOSEL_BIT       7
`define BDR_SI_LSB          8
`define BDR_RUN_BIT         0
`define BDR_DIR_BIT         1
`define BDR_BRAKE_BIT       2
`define BDR_RESTART_BIT     3
`define BDR_DUTY_LSB        4
`define BDR_HALT_BIT        9
`define BDR_MODE_LSB        10
`define BDR_SUM_BIT         15
`define BDR_POR_BIT         14
`define BDR_SERR_BIT        13
`define BDR_GAIN_BIAS       5'd7
`define BDR_DUTY_BASE       7'd7
`define BDR_DUTY_STEP       7'd3

// Interrupt status bits.
`define BDR_IRQ_FAULT       0
`define BDR_IRQ_SERR        1
`define BDR_IRQ_HALT        2
`define BDR_IRQ_W           3
`endif

// file: core/bdr_pkg.sv
package bdr_pkg;

  // Motor control modes held in the run register.
  typedef enum logic [1:0] {
    BDR_MODE_INDIRECT_DUTY,
    BDR_MODE_DIRECT_DUTY,
    BDR_MODE_CURRENT_LOOP,
    BDR_MODE_SPEED_LOOP
  } bdr_mode_type;

  // Raw fault detector outputs, most significant report bit first.
  typedef struct packed {
    logic temp_warning;
    logic overtemp_shutdown;
    logic sync_lost;
    logic supply_undervolt;
    logic phase_a_upper_fault;
    logic phase_a_lower_fault;
    logic phase_b_upper_fault;
    logic phase_b_lower_fault;
    logic phase_c_upper_fault;
    logic phase_c_lower_fault;
  } bdr_fault_type;

  // Settings handed to the motor control logic.
  typedef struct packed {
    bdr_mode_type control_mode_sel;
    logic [4:0]   startup_duty;
    logic [3:0]   phase_lead;
    logic [4:0]   prop_gain_shift;
    logic [4:0]   integ_gain_shift;
    logic [6:0]   duty_cmd_pct;
    logic         auto_restart;
    logic         brake_active;
    logic         motor_enable;
  } bdr_motor_cmd_type;

endpackage

// file: core/bdr_sync.sv
module bdr_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Asynchronous level in, synchronised level out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // Two stages; only the second stage reads the first.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// file: core/bdr_rate_div.sv
module bdr_rate_div #(
  parameter int INC_W = 16,
  parameter int MOD   = 5000000
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Increment per clock; tick rate is clock times inc over MOD.
  input  wire logic [INC_W-1:0] inc,
  output logic                  tick
);

  localparam int ACC_W = $clog2(MOD) + 2;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] sum;

  // Phase accumulator gives exact average rates without a divider.
  assign sum = acc_reg + ACC_W'(inc);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end else if (sum >= ACC_W'(MOD)) begin
      acc_reg <= sum - ACC_W'(MOD);
      tick    <= 1'b1;
    end else begin
      acc_reg <= sum;
      tick    <= 1'b0;
    end
  end

endmodule

// file: core/bdr_regs.sv
`include "bdr_defs.svh"

module bdr_regs #(
  parameter int START_MOD = `BDR_START_MOD,
  parameter int MAX_MOD   = `BDR_MAX_MOD
) (
  // Clock and reset.
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // Register port.
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [15:0]                reg_rdata,
  // Events from the serial front end and the motor logic.
  input  wire logic                       serial_error,
  input  wire logic                       commutate_step,
  input  wire logic                       pwm_active,
  input  wire logic [6:0]                 pwm_duty_pct,
  input  wire logic                       electrical_freq_signal,
  input  wire logic                       commutation_freq_signal,
  // Fault detectors, asynchronous to the core clock.
  input  wire bdr_pkg::bdr_fault_type     fault_raw,
  // Outputs to the drive stage.
  output bdr_pkg::bdr_motor_cmd_type      motor_cmd,
  output logic [2:0]                      commutation_state,
  output logic                            startup_tick,
  output logic                            max_rate_tick,
  output logic                            speed_out_pin,
  output logic                            irq
);
  import bdr_pkg::*;

  typedef enum logic [2:0] {
    COMM_S1, COMM_S2, COMM_S3, COMM_S4, COMM_S5, COMM_S6
  } bdr_comm_type;

  logic [15:0]          startup_reg;
  logic [15:0]          limits_reg;
  logic [15:0]          run_reg;
  logic [15:0]          mask_reg;
  logic [15:0]          report_reg;
  logic [15:0]          report_next;
  logic [15:0]          reg_rdata_next;
  logic [`BDR_IRQ_W-1:0] irq_stat_reg;
  logic [`BDR_IRQ_W-1:0] irq_en_reg;
  logic [`BDR_IRQ_W-1:0] irq_event;
  logic                 halt_reg;
  bdr_comm_type         comm_reg;
  bdr_comm_type         comm_next;
  bdr_fault_type        fault_sync;
  logic [15:0]          fault_word;
  logic [15:0]          fault_live;
  logic                 new_fault;
  logic                 report_rd;
  logic                 stopped;
  logic [4:0]           start_inc;
  logic [15:0]          max_inc;
  logic [2:0]           max_code;
  logic [4:0]           duty_code;

  // Place the fault struct at its report and mask bit positions.
  function automatic logic [15:0] place_faults(input bdr_fault_type f);
    logic [15:0] w;
    w     = 16'h0000;
    w[11] = f.temp_warning;
    w[10] = f.overtemp_shutdown;
    w[9]  = f.sync_lost;
    w[7]  = f.supply_undervolt;
    w[5]  = f.phase_a_upper_fault;
    w[4]  = f.phase_a_lower_fault;
    w[3]  = f.phase_b_upper_fault;
    w[2]  = f.phase_b_lower_fault;
    w[1]  = f.phase_c_upper_fault;
    w[0]  = f.phase_c_lower_fault;
    return w;
  endfunction

  // Fault comparators are analog, so they cross two flip-flops first.
  bdr_sync #(
    .W($bits(bdr_fault_type))
  ) u_fault_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (fault_raw),
    .sync_out (fault_sync)
  );

  // Detectors whose mask bit is set are ignored entirely.
  assign fault_word = place_faults(fault_sync);
  assign fault_live = fault_word & ~mask_reg & `BDR_FAULT_BITS;
  assign new_fault  = |(fault_live & ~report_reg);
  assign report_rd  = reg_rd && (reg_addr == `BDR_ADDR_REPORT);

  // Configuration registers; bits above the fields read as zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      startup_reg <= `BDR_STARTUP_RST;
      limits_reg  <= `BDR_LIMITS_RST;
    end else if (reg_wr) begin
      if (reg_addr == `BDR_ADDR_STARTUP) begin
        startup_reg <= reg_wdata & `BDR_CFG_BITS;
      end else if (reg_addr == `BDR_ADDR_LIMITS) begin
        limits_reg <= reg_wdata & `BDR_CFG_BITS;
      end
    end
  end

  // Run register; run and restart come up set so the motor starts alone.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_reg <= `BDR_RUN_RST;
    end else if (reg_wr && reg_addr == `BDR_ADDR_RUN) begin
      run_reg <= reg_wdata & `BDR_CFG_BITS;
    end
  end

  // Fault mask register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_reg <= 16'h0000;
    end else if (reg_wr && reg_addr == `BDR_ADDR_MASK) begin
      mask_reg <= reg_wdata & `BDR_FAULT_BITS;
    end
  end

  // Report flags are sticky and clear when the report is read. A flag that
  // is still active, or an error arriving in the read cycle, survives the
  // clear, so no event is lost between read and clear.
  always_comb begin
    report_next = report_reg;
    if (report_rd) begin
      report_next = 16'h0000;
    end
    report_next                = report_next | fault_live;
    report_next[`BDR_SERR_BIT] = report_next[`BDR_SERR_BIT] | serial_error;
    report_next[`BDR_SUM_BIT]  = |report_next[14:0];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      report_reg <= `BDR_REPORT_RST;
    end else begin
      report_reg <= report_next;
    end
  end

  // Halt on fault latches the stop until the report is read and clean, or until the halt bit is cleared.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      halt_reg <= 1'b0;
    end else if (run_reg[`BDR_HALT_BIT] && |fault_live) begin
      halt_reg <= 1'b1;
    end else if (report_rd || !run_reg[`BDR_HALT_BIT]) begin
      halt_reg <= 1'b0;
    end
  end

  assign stopped = !run_reg[`BDR_RUN_BIT] || halt_reg;

  // Interrupt events: new fault, serial error, and a stop caused by a fault.
  assign irq_event[`BDR_IRQ_FAULT] = new_fault;
  assign irq_event[`BDR_IRQ_SERR]  = serial_error;
  assign irq_event[`BDR_IRQ_HALT]  = run_reg[`BDR_HALT_BIT] && |fault_live && !halt_reg;

  // Sticky status; a set in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else if (reg_wr && reg_addr == `BDR_ADDR_IRQ_CLR) begin
      irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`BDR_IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_en_reg <= '0;
    end else if (reg_wr && reg_addr == `BDR_ADDR_IRQ_EN) begin
      irq_en_reg <= reg_wdata[`BDR_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  // Read data are captured one cycle after the strobe; unmapped reads zero.
  always_comb begin
    reg_rdata_next = 16'h0000;
    if (reg_addr == `BDR_ADDR_STARTUP) begin
      reg_rdata_next = startup_reg;
    end else if (reg_addr == `BDR_ADDR_LIMITS) begin
      reg_rdata_next = limits_reg;
    end else if (reg_addr == `BDR_ADDR_RUN) begin
      reg_rdata_next = run_reg;
    end else if (reg_addr == `BDR_ADDR_MASK) begin
      reg_rdata_next = mask_reg;
    end else if (reg_addr == `BDR_ADDR_REPORT) begin
      reg_rdata_next = report_reg;
    end else if (reg_addr == `BDR_ADDR_IRQ_STAT) begin
      reg_rdata_next = {{(16 - `BDR_IRQ_W){1'b0}}, irq_stat_reg};
    end else if (reg_addr == `BDR_ADDR_IRQ_EN) begin
      reg_rdata_next = {{(16 - `BDR_IRQ_W){1'b0}}, irq_en_reg};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_next;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Rate generators: start rate in 2 Hz steps, ceiling in 0.1 Hz steps.
  assign start_inc = {1'b0, startup_reg[`BDR_SS_LSB +: 4]} + 5'd1;
  assign max_code  = limits_reg[`BDR_MAXR_LSB +: 3];
  assign max_inc   = 16'(16'h0100 << max_code) - 16'h0001;

  bdr_rate_div #(
    .INC_W (5),
    .MOD   (START_MOD)
  ) u_start_rate (
    .core_clk (core_clk),
    .rst      (rst),
    .inc      (start_inc),
    .tick     (startup_tick)
  );

  bdr_rate_div #(
    .INC_W (16),
    .MOD   (MAX_MOD)
  ) u_max_rate (
    .core_clk (core_clk),
    .rst      (rst),
    .inc      (max_inc),
    .tick     (max_rate_tick)
  );

  // Commutation sequence; held while stopped so the motor coasts.
  always_comb begin
    comm_next = comm_reg;
    if (commutate_step && !stopped) begin
      case (comm_reg)
        COMM_S1: comm_next = run_reg[`BDR_DIR_BIT] ? COMM_S6 : COMM_S2;
        COMM_S2: comm_next = run_reg[`BDR_DIR_BIT] ? COMM_S1 : COMM_S3;
        COMM_S3: comm_next = run_reg[`BDR_DIR_BIT] ? COMM_S2 : COMM_S4;
        COMM_S4: comm_next = run_reg[`BDR_DIR_BIT] ? COMM_S3 : COMM_S5;
        COMM_S5: comm_next = run_reg[`BDR_DIR_BIT] ? COMM_S4 : COMM_S6;
        COMM_S6: comm_next = run_reg[`BDR_DIR_BIT] ? COMM_S5 : COMM_S1;
        default: comm_next = COMM_S1;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      comm_reg <= COMM_S1;
    end else begin
      comm_reg <= comm_next;
    end
  end

  // States are reported as 1 to 6.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      commutation_state <= 3'h1;
    end else begin
      commutation_state <= 3'(comm_next) + 3'h1;
    end
  end

  // Speed output follows the selected rate signal.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      speed_out_pin <= 1'b0;
    end else if (limits_reg[`BDR_SOSEL_BIT]) begin
      speed_out_pin <= commutation_freq_signal;
    end else begin
      speed_out_pin <= electrical_freq_signal;
    end
  end

  assign duty_code = run_reg[`BDR_DUTY_LSB +: 5];

  // Decoded settings for the drive logic, all from flip-flops.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      motor_cmd <= '0;
    end else begin
      motor_cmd.control_mode_sel <= bdr_mode_type'(run_reg[`BDR_MODE_LSB +: 2]);
      motor_cmd.startup_duty     <= {1'b0, startup_reg[`BDR_SDUTY_LSB +: 4]} + 5'd1;
      motor_cmd.phase_lead       <= limits_reg[`BDR_LEAD_LSB +: 4];
      motor_cmd.prop_gain_shift  <= {1'b0, startup_reg[`BDR_SP_LSB +: 4]} - `BDR_GAIN_BIAS;
      motor_cmd.integ_gain_shift <= {1'b0, limits_reg[`BDR_SI_LSB +: 4]} - `BDR_GAIN_BIAS;
      if (duty_code == 5'd0) begin
        motor_cmd.duty_cmd_pct <= pwm_duty_pct;
      end else begin
        motor_cmd.duty_cmd_pct <= `BDR_DUTY_BASE + 7'(duty_code) * `BDR_DUTY_STEP;
      end
      motor_cmd.auto_restart <= run_reg[`BDR_RESTART_BIT];
      motor_cmd.brake_active <= run_reg[`BDR_BRAKE_BIT] && !pwm_active && !stopped;
      motor_cmd.motor_enable <= !stopped;
    end
  end

endmodule

// file: tb/bdr_regs_chk.sv
module bdr_regs_chk
  import bdr_pkg::*;
#(
  parameter int START_MOD = 64,
  parameter int MAX_MOD   = 2048
) (
  // Clock and reset.
  input wire logic                     core_clk,
  input wire logic                     rst,
  // Register port.
  input wire logic [3:0]               reg_addr,
  input wire logic [15:0]              reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [15:0]              reg_rdata,
  // Motor side.
  input wire logic                     commutate_step,
  input wire logic                     electrical_freq_signal,
  input wire logic                     commutation_freq_signal,
  input wire bdr_pkg::bdr_motor_cmd_type motor_cmd,
  input wire logic [2:0]               commutation_state,
  input wire logic                     speed_out_pin,
  input wire logic                     irq
);
  logic [15:0] st_sh;
  logic [15:0] lim_sh;
  logic [15:0] run_sh;
  logic [1:0]  settle_cnt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Shadow copies of the settings; the count says how long they have been stable.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_sh      <= 16'h0773;
      lim_sh     <= 16'h0758;
      run_sh     <= 16'h0009;
      settle_cnt <= 2'h0;
    end else begin
      if (reg_wr) settle_cnt <= 2'h0;
      else if (settle_cnt != 2'h3) settle_cnt <= settle_cnt + 2'h1;
      if (reg_wr && reg_addr == 4'h0) st_sh <= reg_wdata;
      if (reg_wr && reg_addr == 4'h1) lim_sh <= reg_wdata;
      if (reg_wr && reg_addr == 4'h2) run_sh <= reg_wdata;
    end
  end

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  a_state_legal: assert property (commutation_state inside {[3'd1:3'd6]})
    else $error("commutation state out of range");
  a_step_forward: assert property (commutate_step && motor_cmd.motor_enable && !run_sh[1]
    && settle_cnt == 2'h3 |=> commutation_state ==
    ($past(commutation_state) == 3'd6 ? 3'd1 : $past(commutation_state) + 3'd1))
    else $error("forward step wrong");
  a_step_reverse: assert property (commutate_step && motor_cmd.motor_enable && run_sh[1]
    && settle_cnt == 2'h3 |=> commutation_state ==
    ($past(commutation_state) == 3'd1 ? 3'd6 : $past(commutation_state) - 3'd1))
    else $error("reverse step wrong");
  a_coast_when_off: assert property (settle_cnt == 2'h3 && !run_sh[0]
    |-> !motor_cmd.motor_enable ##1 $stable(commutation_state))
    else $error("motor not coasting with run clear");
  a_cfg_decode: assert property (settle_cnt == 2'h3 |->
    motor_cmd.startup_duty == {1'b0, st_sh[7:4]} + 5'd1 && motor_cmd.phase_lead == lim_sh[3:0]
    && motor_cmd.integ_gain_shift == {1'b0, lim_sh[11:8]} - 5'd7)
    else $error("configuration decode wrong");
  a_run_decode: assert property (settle_cnt == 2'h3 |->
    motor_cmd.control_mode_sel == bdr_mode_type'(run_sh[11:10])
    && motor_cmd.auto_restart == run_sh[3])
    else $error("run register decode wrong");
  a_duty_code: assert property (settle_cnt == 2'h3 && run_sh[8:4] != 5'h00
    |-> motor_cmd.duty_cmd_pct == 7'd7 + 7'd3 * {2'b00, run_sh[8:4]})
    else $error("serial duty wrong");
  a_brake_off: assert property (settle_cnt == 2'h3 && !run_sh[2] |-> !motor_cmd.brake_active)
    else $error("brake active while disabled");
  a_speed_select: assert property (settle_cnt == 2'h3 |-> speed_out_pin ==
    ($past(lim_sh[7]) ? $past(commutation_freq_signal) : $past(electrical_freq_signal)))
    else $error("speed output source wrong");

  c_report_read: cover property (reg_rd && reg_addr == 4'h4);
  c_irq_raised: cover property ($rose(irq));
  c_reverse_step: cover property (commutate_step && run_sh[1] && motor_cmd.motor_enable);
endmodule

bind bdr_regs bdr_regs_chk #(.START_MOD(START_MOD), .MAX_MOD(MAX_MOD)) u_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .commutate_step(commutate_step),
  .electrical_freq_signal(electrical_freq_signal),
  .commutation_freq_signal(commutation_freq_signal), .motor_cmd(motor_cmd),
  .commutation_state(commutation_state), .speed_out_pin(speed_out_pin), .irq(irq));

// file: tb/bdr_host_model.sv
module bdr_host_model (
  // Clock.
  input  wire logic        core_clk,
  // Register port.
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // The host starts idle; strobes never rise before the bench asks.
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write; the gap before the next call avoids a double drive.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read; the data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// file: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bdr_pkg::*;

  logic core_clk, rst, reg_wr, reg_rd, serial_error, commutate_step, pwm_active;
  logic electrical_freq_signal, commutation_freq_signal, startup_tick, max_rate_tick;
  logic speed_out_pin, irq;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [6:0]  pwm_duty_pct;
  logic [2:0]  commutation_state, s;
  bdr_fault_type     fault_raw;
  bdr_motor_cmd_type motor_cmd;
  int failures = 0;
  int n_tests = 0;
  logic [15:0] dflt [4] = '{16'h0773, 16'h0758, 16'h0009, 16'h0000};

  bdr_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  bdr_regs #(.START_MOD(64), .MAX_MOD(2048)) dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_error(serial_error), .commutate_step(commutate_step),
    .pwm_active(pwm_active), .pwm_duty_pct(pwm_duty_pct),
    .electrical_freq_signal(electrical_freq_signal),
    .commutation_freq_signal(commutation_freq_signal), .fault_raw(fault_raw),
    .motor_cmd(motor_cmd), .commutation_state(commutation_state),
    .startup_tick(startup_tick), .max_rate_tick(max_rate_tick),
    .speed_out_pin(speed_out_pin), .irq(irq));

  // Free-running 10 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    host.rd(a, rv);
    chk(rv, e);
  endtask

  task automatic step;
    @(posedge core_clk) commutate_step <= 1'b1;
    @(posedge core_clk) commutate_step <= 1'b0;
    #1;
  endtask

  task automatic set_fault(input logic [9:0] f);
    @(posedge core_clk) fault_raw <= bdr_fault_type'(f);
  endtask

  // Defaults, the one-shot power-on flag and an unmapped address.
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rdchk(4'(i), dflt[i]);
    rdchk(4'h4, 16'hc000);
    rdchk(4'h4, 16'h0000);
    rdchk(4'h9, 16'h0000);
    chk(16'(motor_cmd.startup_duty), 16'h0008);
    chk(16'(motor_cmd.phase_lead), 16'h0008);
  endtask

  // All ones into every setting; only the defined bits may stick.
  task automatic t_write;
    logic [15:0] keep [4] = '{16'h0fff, 16'h0fff, 16'h0fff, 16'h0ebf};
    for (int i = 0; i < 4; i++) host.wr(4'(i), 16'hffff);
    host.wr(4'h4, 16'hffff);
    for (int i = 0; i < 4; i++) rdchk(4'(i), keep[i]);
    rdchk(4'h4, 16'h0000);
    chk(16'(motor_cmd.integ_gain_shift), 16'h0008);
    chk(16'(motor_cmd.startup_duty), 16'h0010);
    for (int i = 0; i < 4; i++) host.wr(4'(i), dflt[i]);
    cyc(3);
  endtask

  // Forward and reverse stepping, then a step that must be held with run clear.
  task automatic t_commute;
    for (int i = 0; i < 6; i++) begin
      s = commutation_state;
      step;
      chk(16'(commutation_state), 16'(s == 3'd6 ? 3'd1 : s + 3'd1));
    end
    host.wr(4'h2, 16'h000b);
    cyc(3);
    for (int i = 0; i < 6; i++) begin
      s = commutation_state;
      step;
      chk(16'(commutation_state), 16'(s == 3'd1 ? 3'd6 : s - 3'd1));
    end
    host.wr(4'h2, 16'h0008);
    cyc(3);
    s = commutation_state;
    step;
    chk(16'(commutation_state), 16'(s));
    chk(16'(motor_cmd.motor_enable), 16'h0000);
  endtask

  // Every mode with its own duty code (1, 10, 30, 31), then measured duty, restart and brake.
  task automatic t_duty;
    logic [15:0] w [4] = '{16'h0019, 16'h04a9, 16'h09e9, 16'h0df9};
    logic [15:0] d [4] = '{16'd10, 16'd37, 16'd97, 16'd100};
    for (int i = 0; i < 4; i++) begin
      host.wr(4'h2, w[i]);
      cyc(3);
      chk(16'(motor_cmd.duty_cmd_pct), d[i]);
      chk(16'(motor_cmd.control_mode_sel), 16'(i));
    end
    host.wr(4'h2, 16'h0001);
    cyc(3);
    chk(16'(motor_cmd.duty_cmd_pct), 16'd42);
    chk(16'(motor_cmd.auto_restart), 16'h0000);
    host.wr(4'h2, 16'h0005);
    cyc(3);
    chk(16'(motor_cmd.brake_active), 16'h0001);
    @(posedge core_clk) pwm_active <= 1'b1;
    cyc(2);
    chk(16'(motor_cmd.brake_active), 16'h0000);
    @(posedge core_clk) pwm_active <= 1'b0;
    host.wr(4'h2, 16'h0009);
    cyc(3);
    chk(16'(motor_cmd.brake_active), 16'h0000);
  endtask

  // Speed output source, then both tick rates over a fixed span.
  task automatic t_rates;
    int a;
    int b;
    a = 0;
    b = 0;
    @(posedge core_clk) electrical_freq_signal <= 1'b1;
    cyc(3);
    chk(16'(speed_out_pin), 16'h0001);
    host.wr(4'h1, 16'h07d8);
    cyc(3);
    chk(16'(speed_out_pin), 16'h0000);
    @(posedge core_clk) commutation_freq_signal <= 1'b1;
    cyc(3);
    chk(16'(speed_out_pin), 16'h0001);
    host.wr(4'h1, 16'h0708);
    cyc(4);
    repeat (2048) begin
      cyc(1);
      if (startup_tick === 1'b1) a++;
      if (max_rate_tick === 1'b1) b++;
    end
    chk(16'(a inside {[127:129]}), 16'h0001);
    chk(16'(b inside {[254:256]}), 16'h0001);
    host.wr(4'h1, 16'h0758);
  endtask

  // Report, interrupt, masking and stop on fail with and without the halt bit.
  task automatic t_faults;
    host.wr(4'h6, 16'h0007);
    set_fault(10'h201);
    cyc(5);
    chk(16'(irq), 16'h0001);
    set_fault(10'h000);
    cyc(4);
    rdchk(4'h4, 16'h8801);
    rdchk(4'h4, 16'h0000);
    host.wr(4'h7, 16'h0007);
    host.wr(4'h3, 16'h0800);
    set_fault(10'h200);
    cyc(5);
    chk(16'(irq), 16'h0000);
    rdchk(4'h4, 16'h0000);
    set_fault(10'h000);
    host.wr(4'h3, 16'h0000);
    host.wr(4'h2, 16'h0209);
    set_fault(10'h100);
    cyc(6);
    chk(16'(motor_cmd.motor_enable), 16'h0000);
    rdchk(4'h5, 16'h0005);
    set_fault(10'h000);
    host.wr(4'h2, 16'h0009);
    rdchk(4'h4, 16'h8400);
    cyc(3);
    chk(16'(motor_cmd.motor_enable), 16'h0001);
    set_fault(10'h100);
    cyc(6);
    chk(16'(motor_cmd.motor_enable), 16'h0001);
    set_fault(10'h000);
    cyc(4);
    rdchk(4'h4, 16'h8400);
    host.wr(4'h7, 16'h0007);
    @(posedge core_clk) serial_error <= 1'b1;
    @(posedge core_clk) serial_error <= 1'b0;
    cyc(3);
    rdchk(4'h4, 16'ha000);
    rdchk(4'h5, 16'h0002);
    host.wr(4'h7, 16'h0007);
    cyc(1);
    chk(16'(irq), 16'h0000);
  endtask

  // Hang guard, sized well beyond the expected run.
  initial begin
    #3000000;
    failures++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    serial_error = 1'b0;
    commutate_step = 1'b0;
    pwm_active = 1'b0;
    pwm_duty_pct = 7'd42;
    electrical_freq_signal = 1'b0;
    commutation_freq_signal = 1'b0;
    fault_raw = bdr_fault_type'(10'h000);
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    t_reset;
    t_write;
    t_commute;
    t_duty;
    t_rates;
    t_faults;
    report_and_stop;
  end
endmodule
